// file: scp_sync.sv
// Constants package and pin synchroniser for the serial command port
`timescale 1ns/1ps
`default_nettype none
package scp_pkg;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 16;
  localparam int CNT_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_NOP = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_FIRST = 4'h1;
  localparam logic [ADDR_W-1:0] CTRL_LAST = 4'hb;
  localparam logic [ADDR_W-1:0] STAT_THERMAL = 4'he;
  localparam logic [ADDR_W-1:0] STAT_SERIAL = 4'hf;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [15:0] RESP_RESET = 16'h0000;
  localparam int HI_MSB = 15;
  localparam int HI_LSB = 12;
  localparam int LO_MSB = 11;
  localparam int LO_LSB = 8;
  localparam int FLAG_BIT = 0;
  localparam int BIT_IDX_W = $clog2(FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
endpackage

module scp_sync3 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rst_val,
  input wire logic async_in,
  output logic stable_out
);
  logic s1_r, s2_r, s3_r, out_r;
  logic s1_nxt, s2_nxt, s3_nxt, out_nxt;

  always_comb begin
    s1_nxt = async_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    // A change counts only once the last two stages agree
    out_nxt = (s2_r == s3_r) ? s3_r : out_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // Start at the pin's idle level so no false edge follows reset
      s1_r <= rst_val;
      s2_r <= rst_val;
      s3_r <= rst_val;
      out_r <= rst_val;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      out_r <= out_nxt;
    end
  end

  assign stable_out = out_r;
endmodule

`default_nettype wire

// file: scp_port.sv
// Serial command port: link-side shifter and system-side register commit
`timescale 1ns/1ps
`default_nettype none

module scp_port
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic thermal_warning,
  output logic [NUM_REGS*DATA_W-1:0] control_regs,
  output logic thermal_flag,
  output logic serial_error
);

  // ---------------- Link domain (serial_clk) ----------------
  // Counters run free across frames; the system side subtracts its own
  // base, so nothing has to be cleared by chip select itself.
  logic [FRAME_BITS-1:0] rx_sh_r, rx_sh_nxt;
  logic [CNT_W-1:0] rise_cnt_r, rise_cnt_nxt;
  logic [CNT_W-1:0] fall_cnt_r, fall_cnt_nxt;
  logic out_bit_r, out_bit_nxt;
  logic [CNT_W-1:0] base_r;
  logic [FRAME_BITS-1:0] tx_word_r;
  logic [CNT_W-1:0] rise_rel, fall_rel;

  // Counts run modulo their width, so a span stays right across wraps
  function automatic logic [CNT_W-1:0] cnt_span(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] base
  );
    cnt_span = cnt - base;
  endfunction

  function automatic logic [CNT_W-1:0] cnt_bump(input logic [CNT_W-1:0] cnt);
    cnt_bump = cnt + CNT_STEP;
  endfunction

  // True when a span ends on a frame boundary
  function automatic logic on_boundary(input logic [CNT_W-1:0] span);
    on_boundary = (span[BIT_IDX_W-1:0] == '0);
  endfunction

  assign rise_rel = cnt_span(rise_cnt_r, base_r);
  assign fall_rel = cnt_span(fall_cnt_r, base_r);

  always_comb begin
    rx_sh_nxt = rx_sh_r;
    rise_cnt_nxt = rise_cnt_r;
    if (!chip_select_n) begin
      rx_sh_nxt = {rx_sh_r[FRAME_BITS-2:0], serial_in};
      rise_cnt_nxt = cnt_bump(rise_cnt_r);
    end
  end

  always_ff @(posedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_sh_r <= RESP_RESET;
      rise_cnt_r <= CNT_ZERO;
    end else begin
      rx_sh_r <= rx_sh_nxt;
      rise_cnt_r <= rise_cnt_nxt;
    end
  end

  always_comb begin
    fall_cnt_nxt = fall_cnt_r;
    out_bit_nxt = out_bit_r;
    if (!chip_select_n) begin
      fall_cnt_nxt = cnt_bump(fall_cnt_r);
      // Past the first frame the device passes the bits it received
      // sixteen clocks earlier, which makes daisy chaining work.
      if (rise_rel < 8'(FRAME_BITS)) begin
        out_bit_nxt = tx_word_r[FRAME_BITS-1-int'(rise_rel[BIT_IDX_W-1:0])];
      end else begin
        out_bit_nxt = rx_sh_r[FRAME_BITS-1];
      end
    end
  end

  always_ff @(negedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_cnt_r <= CNT_ZERO;
      out_bit_r <= 1'b0;
    end else begin
      fall_cnt_r <= fall_cnt_nxt;
      out_bit_r <= out_bit_nxt;
    end
  end

  // Before the first falling edge the word's top bit must already be on
  // the line, so it is taken straight from the held response word.
  assign serial_out = (fall_rel == CNT_ZERO) ? tx_word_r[FRAME_BITS-1] : out_bit_r;
  assign serial_out_en = ~chip_select_n;

  // ---------------- System domain (clk) ----------------
  logic cs_n_s, therm_s;
  // Crossing: link registers are read only after select has risen and the
  // serial clock is idle; the response word also changes only then, so
  // a gap of six system clocks between frames keeps both sides quiet.
  typedef enum logic [2:0] {
    SCP_IDLE = 3'h1,
    SCP_BUSY = 3'h2,
    SCP_DONE = 3'h4
  } scp_frame_e;
  scp_frame_e frame_st_r, frame_st_nxt;

  scp_sync3 u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .rst_val(1'b1),
    .async_in(chip_select_n),
    .stable_out(cs_n_s)
  );

  scp_sync3 u_therm_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .rst_val(1'b0),
    .async_in(thermal_warning),
    .stable_out(therm_s)
  );

  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic [DATA_W-1:0] regs_nxt [NUM_REGS];
  logic [CNT_W-1:0] base_nxt;
  logic [FRAME_BITS-1:0] tx_word_nxt;
  logic therm_r, therm_nxt;
  logic serr_r, serr_nxt;

  function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
    is_ctrl = (a >= CTRL_FIRST) && (a <= CTRL_LAST);
  endfunction

  function automatic logic is_stat(input logic [ADDR_W-1:0] a);
    is_stat = (a > CTRL_LAST);
  endfunction

  // One status byte with its flag in place
  function automatic logic [DATA_W-1:0] flag_byte(input logic f);
    flag_byte = REG_RESET;
    flag_byte[FLAG_BIT] = f;
  endfunction

  // Read value of one location; status flags read as their sticky state
  function automatic logic [DATA_W-1:0] read_loc(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] ctl,
    input logic th,
    input logic se
  );
    read_loc = REG_RESET;
    if (is_ctrl(a)) begin
      read_loc = ctl;
    end else if (is_stat(a)) begin
      case (a)
        STAT_THERMAL: read_loc = flag_byte(th);
        STAT_SERIAL: read_loc = flag_byte(se);
        default: read_loc = REG_RESET;
      endcase
    end
  endfunction

  // True when either nibble of the command names the location
  function automatic logic names_loc(
    input logic [ADDR_W-1:0] hi,
    input logic [ADDR_W-1:0] lo,
    input logic [ADDR_W-1:0] loc
  );
    names_loc = (hi == loc) || (lo == loc);
  endfunction

  logic cs_rise;
  logic [ADDR_W-1:0] hi_a, lo_a;
  logic [DATA_W-1:0] wdata;
  logic frame_ok, frame_bad;

  always_comb begin
    cs_rise = cs_n_s && (frame_st_r == SCP_BUSY);
    hi_a = rx_sh_r[HI_MSB:HI_LSB];
    lo_a = rx_sh_r[LO_MSB:LO_LSB];
    wdata = rx_sh_r[DATA_W-1:0];
    frame_ok = cs_rise && (rise_rel != CNT_ZERO) && on_boundary(rise_rel);
    frame_bad = cs_rise && !on_boundary(rise_rel);
  end

  // Frame tracker on the synchronised select
  always_comb begin
    frame_st_nxt = frame_st_r;
    case (frame_st_r)
      SCP_IDLE: begin
        if (!cs_n_s) begin
          frame_st_nxt = SCP_BUSY;
        end
      end
      SCP_BUSY: begin
        if (cs_n_s) begin
          frame_st_nxt = SCP_DONE;
        end
      end
      SCP_DONE: begin
        frame_st_nxt = cs_n_s ? SCP_IDLE : SCP_BUSY;
      end
      default: begin
        frame_st_nxt = SCP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_st_r <= SCP_IDLE;
    end else begin
      frame_st_r <= frame_st_nxt;
    end
  end

  // Nothing changes until chip select rises with a whole frame
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    if (frame_ok && is_ctrl(hi_a)) begin
      regs_nxt[hi_a] = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Response word for the next frame and the count base it starts from
  always_comb begin
    base_nxt = base_r;
    tx_word_nxt = tx_word_r;
    if (cs_rise) begin
      base_nxt = rise_cnt_r;
    end
    if (frame_ok) begin
      // Upper byte shows the freshly written value for a write
      if (is_ctrl(hi_a)) begin
        tx_word_nxt[FRAME_BITS-1:DATA_W] = wdata;
      end else begin
        tx_word_nxt[FRAME_BITS-1:DATA_W] =
          read_loc(hi_a, regs_r[hi_a], therm_r, serr_r);
      end
      tx_word_nxt[DATA_W-1:0] = read_loc(lo_a, regs_r[lo_a], therm_r, serr_r);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      base_r <= CNT_ZERO;
      tx_word_r <= RESP_RESET;
    end else begin
      base_r <= base_nxt;
      tx_word_r <= tx_word_nxt;
    end
  end

  // Read clears a flag, but a warning still present sets it again
  always_comb begin
    therm_nxt = therm_r | therm_s;
    serr_nxt = serr_r | frame_bad;
    if (frame_ok && names_loc(hi_a, lo_a, STAT_THERMAL)) begin
      therm_nxt = therm_s;
    end
    if (frame_ok && names_loc(hi_a, lo_a, STAT_SERIAL)) begin
      serr_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      therm_r <= 1'b0;
      serr_r <= 1'b0;
    end else begin
      therm_r <= therm_nxt;
      serr_r <= serr_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      control_regs[i*DATA_W +: DATA_W] = regs_r[i];
    end
  end

  assign thermal_flag = therm_r;
  assign serial_error = serr_r;
  // The device has no path to start a frame: it only answers
endmodule

`default_nettype wire

// file: scp_port_assertions.sv
// Concurrent checks on the serial command port pins
`timescale 1ns/1ps
`default_nettype none
module scp_port_assertions
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic thermal_warning,
  input wire logic [NUM_REGS*DATA_W-1:0] control_regs,
  input wire logic thermal_flag,
  input wire logic serial_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_en_sel: assert property (serial_out_en == !chip_select_n)
    else $error("drive enable differs from select");
  a_regs_sel: assert property (!chip_select_n [*5] |-> $stable(control_regs))
    else $error("registers moved inside a frame");
  a_fixed_zero: assert property (control_regs[7:0] == 8'h00 && control_regs[127:96] == 32'h0)
    else $error("unwritable register changed");
  a_th_set: assert property (thermal_warning [*6] |-> thermal_flag)
    else $error("thermal flag not set");
  a_th_clear: assert property ($fell(thermal_flag) |-> $past(chip_select_n, 2))
    else $error("thermal flag cleared mid frame");
  a_err_clear: assert property ($fell(serial_error) |-> $past(chip_select_n, 2))
    else $error("error flag cleared mid frame");
  a_regs_idle: assert property (!$stable(control_regs) |-> $past(chip_select_n, 2))
    else $error("registers moved before select rise");
  a_out_hi: assert property (serial_clk && $past(serial_clk) && !chip_select_n &&
    !$past(chip_select_n) |-> $stable(serial_out)) else $error("output moved while clock high");
endmodule
bind scp_port scp_port_assertions scp_port_assertions_inst (.clk, .sys_rst, .serial_clk,
  .chip_select_n, .serial_out, .serial_out_en, .thermal_warning, .control_regs, .thermal_flag,
  .serial_error);
`default_nettype wire

// file: scp_master_model.sv
// Serial master model that shifts frames into the command port
`timescale 1ns/1ps
`default_nettype none
module scp_master_model (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic sdata
);
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Data line is inverted once released so a stale bit never looks valid
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    chip_select_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = tx[i];
      #62.5 serial_clk = 1'b1;
      rx = {rx[30:0], sdata};
      #62.5 serial_clk = 1'b0;
    end
    #62.5 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule
`default_nettype wire

// file: tb_spi_slave_command_port.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_command_port import scp_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic thermal_warning = 1'b0;
  wire serial_clk, chip_select_n, serial_in, serial_out, serial_out_en, sdata;
  logic [NUM_REGS*DATA_W-1:0] control_regs;
  logic thermal_flag;
  logic serial_error;
  logic [31:0] rx;
  int n_errors = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  assign sdata = serial_out_en ? serial_out : 1'bz;
  scp_port scp_port_inst (.clk, .sys_rst, .serial_clk, .chip_select_n, .serial_in, .serial_out,
    .serial_out_en, .thermal_warning, .control_regs, .thermal_flag, .serial_error);
  scp_master_model scp_master_model_inst (.serial_clk, .chip_select_n, .serial_in, .sdata);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] rg(input int i);
    return control_regs[8*i+:8];
  endfunction
  // The model's closing gap also covers the commit delay
  task automatic frame(input int n, input logic [31:0] tx);
    @(posedge clk);
    #2;
    scp_master_model_inst.xfer(n, tx, rx);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_write_read();
    frame(16, 32'h14a5);
    chk(rx, 32'h0);
    chk(rg(1), 32'ha5);
    frame(16, 32'h413c);
    chk(rx, 32'ha500);
    chk(rg(4), 32'h3c);
    frame(16, 32'h0377);
    chk(rx, 32'h3ca5);
    chk(rg(3), 32'h0);
  endtask
  task automatic t_thermal();
    @(posedge clk);
    #2 thermal_warning = 1'b1;
    repeat (10) @(posedge clk);
    #2 thermal_warning = 1'b0;
    repeat (10) @(posedge clk);
    chk(thermal_flag, 32'h1);
    frame(16, 32'he1ff);
    chk(rx, 32'h0);
    chk(thermal_flag, 32'h0);
    chk(rg(1), 32'ha5);
  endtask
  task automatic t_bad_len();
    frame(15, 32'h1fff);
    chk(serial_error, 32'h1);
    chk(rg(1), 32'ha5);
    frame(16, 32'h0f00);
    chk(rx, 32'h01a5);
    chk(serial_error, 32'h0);
  endtask
  task automatic t_daisy();
    frame(32, 32'h2011_5066);
    chk(rx, 32'h0001_2011);
    chk(rg(5), 32'h66);
    chk(rg(2), 32'h0);
    frame(16, 32'h0000);
    chk(rx, 32'h6600);
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    #2 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    t_write_read();
    t_thermal();
    t_bad_len();
    t_daisy();
    end_of_test();
  end
endmodule
`default_nettype wire
